/* File: common/dgc_params.svh */
// What this block does
// R1 - left gain signed half-dB, reset zero
// R2 - negative left codes two's complement to -63.5
// R3 - software avoids left codes 0x31-0x80
// R4 - right gain same encoding, resets 0 dB
// R5 - software avoids right codes 0x31-0x80
// R6 - bit 6 enables left compressor
// R7 - bit 5 enables right compressor
// R8 - bits 4-2 threshold, -3 dB steps
// R9 - bits 1-0 hysteresis 0-3 dB
// R10 - software writes zero to bit 7
// R11 - compressor on keeps channel gains independent
// R12 - gain ramps one step per one/two samples
// R13 - gain applied to every sample of channel
// R14 - compress above threshold, release below hysteresis
`ifndef DGC_PARAMS_SVH
`define DGC_PARAMS_SVH
`define DGC_ADDR_LGAIN 8'h41
`define DGC_ADDR_RGAIN 8'h42
`define DGC_ADDR_COMP  8'h44
`define DGC_GAIN_RST   8'h00
`define DGC_COMP_RST   8'h0f
`define DGC_RD_NONE    8'h00
`define DGC_BIT_LEN    6
`define DGC_BIT_REN    5
`define DGC_THR_HI     4
`define DGC_THR_LO     2
`define DGC_HYS_HI     1
`define DGC_HYS_LO     0
`define DGC_GAIN_MAX   8'sh30
`define DGC_GAIN_MIN   8'sh81
`define DGC_GAIN_BAD   8'h80
`define DGC_GAIN_STEP  8'sh01
`define DGC_STEP_ONE   2'h0
`define DGC_STEP_TWO   2'h1
`define DGC_STEP_NOW   2'h2
`define DGC_LINK_R2L   2'h1
`define DGC_LINK_L2R   2'h2
`define DGC_RED_MAX    6'h18
`define DGC_RED_STEP   6'h01
`define DGC_EXP_OFS    9'h0a8
`define DGC_STEPS_OCT  9'h00c
`define DGC_SHIFT_BASE 9'h01d
`define DGC_MANT_FRAC  15
`define DGC_SMP_MAX    16'sh7fff
`define DGC_SMP_MIN    16'sh8000
`define DGC_FRAC_TAB '{16'h8000, 16'h879c, 16'h8fad, 16'h9838, \
   16'ha145, 16'haadc, 16'hb505, 16'hbfc9, 16'hcb30, 16'hd745, \
   16'he412, 16'hf1a2}
`define DGC_THR_TAB '{16'h5a9d, 16'h4027, 16'h2d6b, 16'h2027, \
   16'h16c3, 16'h101d, 16'h0b68, 16'h0813}
`define DGC_HYS_TAB '{16'h8000, 16'h7215, 16'h65ad, 16'h5a9e}
`endif

/* File: common/dgc_pkg.sv */
package dgc_pkg;
   typedef logic signed [7:0]  dgc_gain_t;
   typedef logic signed [15:0] dgc_smp_t;
   typedef logic [5:0]         dgc_red_t;
   typedef enum logic {DGC_COMP_OFF, DGC_COMP_ON} dgc_comp_t;
endpackage

/* File: common/dgc_chan_if.sv */
interface dgc_chan_if;
   logic               tick;
   dgc_pkg::dgc_smp_t  smp_in;
   dgc_pkg::dgc_gain_t target;
   logic [1:0]         step_mode;
   logic               comp_en;
   logic [2:0]         thr;
   logic [1:0]         hys;
   dgc_pkg::dgc_smp_t  smp_out;
   dgc_pkg::dgc_gain_t applied;
   logic               comp_on;
   logic               out_valid;
   modport ctl (output tick, smp_in, target, step_mode, comp_en, thr, hys,
                input smp_out, applied, comp_on, out_valid);
   modport chan (input tick, smp_in, target, step_mode, comp_en, thr, hys,
                 output smp_out, applied, comp_on, out_valid);
endinterface

/* File: hw/dgc_chan.sv */
`include "dgc_params.svh"
module dgc_chan
(
   input wire logic core_clk,
   input wire logic rst,
   dgc_chan_if.chan ch
);
   localparam logic [15:0] FRAC_TAB [12] = `DGC_FRAC_TAB;
   localparam logic [15:0] THR_TAB [8]   = `DGC_THR_TAB;
   localparam logic [15:0] HYS_TAB [4]   = `DGC_HYS_TAB;

   dgc_pkg::dgc_gain_t tgt_clamp;
   dgc_pkg::dgc_gain_t applied_r;
   dgc_pkg::dgc_gain_t applied_nxt;
   logic               phase_r;
   dgc_pkg::dgc_red_t  red_r;
   dgc_pkg::dgc_comp_t comp_r;
   logic signed [8:0]  total;
   logic [8:0]         tidx;
   logic [8:0]         oct;
   logic [8:0]         rem;
   logic [4:0]         shamt;
   logic signed [32:0] prod;
   logic signed [32:0] scaled;
   dgc_pkg::dgc_smp_t  smp_out_r;
   logic               valid_r;
   logic [15:0]        lvl;
   logic [15:0]        thr_lin;
   logic [31:0]        rel_wide;
   logic [15:0]        rel_lin;

   // R3 R5 reserved codes pinned
   always_comb
   begin
      if (ch.target == `DGC_GAIN_BAD)
         tgt_clamp = `DGC_GAIN_MIN;
      else if (ch.target > `DGC_GAIN_MAX)
         tgt_clamp = `DGC_GAIN_MAX;
      else
         tgt_clamp = ch.target;
   end

   // R12 soft stepping rate
   always_comb
   begin
      applied_nxt = applied_r;
      if (ch.step_mode == `DGC_STEP_NOW)
         applied_nxt = tgt_clamp;
      else if (ch.step_mode != `DGC_STEP_TWO || phase_r)
      begin
         if (tgt_clamp > applied_r)
            applied_nxt = applied_r + `DGC_GAIN_STEP;
         else if (tgt_clamp < applied_r)
            applied_nxt = applied_r - `DGC_GAIN_STEP;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         applied_r <= `DGC_GAIN_RST;
         phase_r   <= 1'b0;
      end
      else if (ch.tick)
      begin
         applied_r <= applied_nxt;
         phase_r   <= ~phase_r;
      end
   end

   // R8 R9 threshold and release level
   assign thr_lin  = THR_TAB[ch.thr];
   assign rel_wide = thr_lin * HYS_TAB[ch.hys];
   assign rel_lin  = 16'(rel_wide >> `DGC_MANT_FRAC);
   assign lvl      = (smp_out_r < 0) ? 16'(-smp_out_r) : 16'(smp_out_r);

   // R14 engage and release with hysteresis
   always_ff @(posedge core_clk)
   begin
      if (rst || !ch.comp_en)
         comp_r <= dgc_pkg::DGC_COMP_OFF;
      else if (ch.tick)
      begin
         unique case (comp_r)
            dgc_pkg::DGC_COMP_OFF:
               if (lvl > thr_lin)
                  comp_r <= dgc_pkg::DGC_COMP_ON;
            dgc_pkg::DGC_COMP_ON:
               if (lvl < rel_lin)
                  comp_r <= dgc_pkg::DGC_COMP_OFF;
         endcase
      end
   end

   // R14 reduction grows while loud
   always_ff @(posedge core_clk)
   begin
      if (rst || !ch.comp_en)
         red_r <= '0;
      else if (ch.tick)
      begin
         if (comp_r == dgc_pkg::DGC_COMP_ON && lvl > thr_lin &&
             red_r < `DGC_RED_MAX)
            red_r <= red_r + `DGC_RED_STEP;
         else if (comp_r == dgc_pkg::DGC_COMP_OFF && red_r != '0)
            red_r <= red_r - `DGC_RED_STEP;
      end
   end

   // R13 per-sample gain, mantissa times power of two
   assign total  = $signed(9'(applied_nxt)) - $signed({3'b000, red_r});
   assign tidx   = unsigned'(total) + `DGC_EXP_OFS;
   assign oct    = tidx / `DGC_STEPS_OCT;
   assign rem    = tidx % `DGC_STEPS_OCT;
   assign shamt  = 5'(`DGC_SHIFT_BASE - oct);
   assign prod   = ch.smp_in * $signed({1'b0, FRAC_TAB[rem[3:0]]});
   assign scaled = prod >>> shamt;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         smp_out_r <= '0;
         valid_r   <= 1'b0;
      end
      else
      begin
         valid_r <= ch.tick;
         if (ch.tick && scaled > 33'(`DGC_SMP_MAX))
            smp_out_r <= `DGC_SMP_MAX;
         else if (ch.tick && scaled < 33'(`DGC_SMP_MIN))
            smp_out_r <= `DGC_SMP_MIN;
         else if (ch.tick)
            smp_out_r <= 16'(scaled);
      end
   end

   assign ch.smp_out   = smp_out_r;
   assign ch.applied   = applied_r;
   assign ch.comp_on   = (comp_r == dgc_pkg::DGC_COMP_ON);
   assign ch.out_valid = valid_r;

   sequence half_idle_s;
      ch.tick && ch.step_mode == `DGC_STEP_TWO && !phase_r;
   endsequence

   step_one_a: assert property (@(posedge core_clk) disable iff (rst) // R12
      ch.tick && ch.step_mode == `DGC_STEP_ONE
      |=> (applied_r - $past(applied_r)) inside {8'sh00, 8'sh01, 8'shff})
      else $error("gain moved more than one step");
   step_half_a: assert property (@(posedge core_clk) disable iff (rst) // R12
      half_idle_s |=> $stable(applied_r))
      else $error("gain moved on idle half period");
   gain_legal_a: assert property (@(posedge core_clk) disable iff (rst) // R2
      applied_r != `DGC_GAIN_BAD && applied_r <= `DGC_GAIN_MAX)
      else $error("applied gain is a reserved code");
   comp_hold_a: assert property (@(posedge core_clk) disable iff (rst) // R14
      comp_r == dgc_pkg::DGC_COMP_ON && ch.comp_en && ch.tick &&
      lvl >= rel_lin |=> comp_r == dgc_pkg::DGC_COMP_ON)
      else $error("compressor released inside hysteresis");
endmodule

/* File: hw/dgc_top.sv */
`include "dgc_params.svh"
module dgc_top
(
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               reg_wr_en,
   input  wire logic               reg_rd_en,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   output logic [7:0]              reg_rdata,
   input  wire logic [1:0]         step_mode,
   input  wire logic [1:0]         link_sel,
   input  wire logic               sample_tick,
   input  wire dgc_pkg::dgc_smp_t  left_in,
   input  wire dgc_pkg::dgc_smp_t  right_in,
   output dgc_pkg::dgc_smp_t       left_out,
   output dgc_pkg::dgc_smp_t       right_out,
   output logic                    out_valid,
   output dgc_pkg::dgc_gain_t      left_gain_applied,
   output dgc_pkg::dgc_gain_t      right_gain_applied,
   output logic                    left_comp_active,
   output logic                    right_comp_active
);
   dgc_pkg::dgc_gain_t lgain_r;
   dgc_pkg::dgc_gain_t rgain_r;
   logic [7:0]         comp_r;
   logic [7:0]         rdata_r;
   logic               comp_any;
   logic               wr_left;
   logic               wr_right;
   logic               wr_comp;
   dgc_pkg::dgc_gain_t ltarget;
   dgc_pkg::dgc_gain_t rtarget;

   dgc_chan_if lch ();
   dgc_chan_if rch ();

   assign wr_left  = reg_wr_en && reg_addr == `DGC_ADDR_LGAIN;
   assign wr_right = reg_wr_en && reg_addr == `DGC_ADDR_RGAIN;
   assign wr_comp  = reg_wr_en && reg_addr == `DGC_ADDR_COMP;

   // R1 R2 left gain storage
   always_ff @(posedge core_clk)
   begin
      if (rst)
         lgain_r <= `DGC_GAIN_RST;
      else if (wr_left)
         lgain_r <= reg_wdata;
   end

   // R4 right gain storage
   always_ff @(posedge core_clk)
   begin
      if (rst)
         rgain_r <= `DGC_GAIN_RST;
      else if (wr_right)
         rgain_r <= reg_wdata;
   end

   // R10 reserved top bit kept as written
   always_ff @(posedge core_clk)
   begin
      if (rst)
         comp_r <= `DGC_COMP_RST;
      else if (wr_comp)
         comp_r <= reg_wdata;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         rdata_r <= `DGC_RD_NONE;
      else if (reg_rd_en)
      begin
         unique case (reg_addr)
            `DGC_ADDR_LGAIN: rdata_r <= lgain_r;
            `DGC_ADDR_RGAIN: rdata_r <= rgain_r;
            `DGC_ADDR_COMP:  rdata_r <= comp_r;
            default:         rdata_r <= `DGC_RD_NONE;
         endcase
      end
   end

   assign reg_rdata = rdata_r;

   // R11 linking ignored while compressing
   assign comp_any = comp_r[`DGC_BIT_LEN] | comp_r[`DGC_BIT_REN];

   always_comb
   begin
      ltarget = lgain_r;
      rtarget = rgain_r;
      if (!comp_any && link_sel == `DGC_LINK_R2L)
         ltarget = rgain_r;
      else if (!comp_any && link_sel == `DGC_LINK_L2R)
         rtarget = lgain_r;
   end

   // R6 left enable and shared settings
   assign lch.tick      = sample_tick;
   assign lch.smp_in    = left_in;
   assign lch.target    = ltarget;
   assign lch.step_mode = step_mode;
   assign lch.comp_en   = comp_r[`DGC_BIT_LEN];
   assign lch.thr       = comp_r[`DGC_THR_HI:`DGC_THR_LO];
   assign lch.hys       = comp_r[`DGC_HYS_HI:`DGC_HYS_LO];

   // R7 right enable and shared settings
   assign rch.tick      = sample_tick;
   assign rch.smp_in    = right_in;
   assign rch.target    = rtarget;
   assign rch.step_mode = step_mode;
   assign rch.comp_en   = comp_r[`DGC_BIT_REN];
   assign rch.thr       = comp_r[`DGC_THR_HI:`DGC_THR_LO];
   assign rch.hys       = comp_r[`DGC_HYS_HI:`DGC_HYS_LO];

   dgc_chan u_left
   (
      .core_clk (core_clk),
      .rst      (rst),
      .ch       (lch.chan)
   );

   dgc_chan u_right
   (
      .core_clk (core_clk),
      .rst      (rst),
      .ch       (rch.chan)
   );

   assign left_out           = lch.smp_out;
   assign right_out          = rch.smp_out;
   assign out_valid          = lch.out_valid;
   assign left_gain_applied  = lch.applied;
   assign right_gain_applied = rch.applied;
   assign left_comp_active   = lch.comp_on;
   assign right_comp_active  = rch.comp_on;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence tick_now_s;
      sample_tick && step_mode == `DGC_STEP_NOW;
   endsequence

   sequence legal_left_s;
      lgain_r != `DGC_GAIN_BAD && lgain_r <= `DGC_GAIN_MAX;
   endsequence

   sequence legal_right_s;
      rgain_r != `DGC_GAIN_BAD && rgain_r <= `DGC_GAIN_MAX;
   endsequence

   reset_values_a: assert property (disable iff (1'b0) // R1 R4
      rst |=> lgain_r == `DGC_GAIN_RST && rgain_r == `DGC_GAIN_RST &&
      comp_r == `DGC_COMP_RST && !left_comp_active && !right_comp_active)
      else $error("register reset value wrong");
   left_write_a: assert property ( // R1
      wr_left |=> lgain_r == $past(reg_wdata))
      else $error("left gain write lost");
   right_write_a: assert property ( // R4
      wr_right |=> rgain_r == $past(reg_wdata))
      else $error("right gain write lost");
   comp_fields_a: assert property ( // R9
      wr_comp |=> lch.thr == $past(reg_wdata[`DGC_THR_HI:`DGC_THR_LO]) &&
      rch.hys == $past(reg_wdata[`DGC_HYS_HI:`DGC_HYS_LO]))
      else $error("compressor fields not routed");
   read_back_a: assert property (
      reg_rd_en && reg_addr == `DGC_ADDR_COMP && !reg_wr_en
      |=> reg_rdata == $past(comp_r))
      else $error("compressor register readback wrong");
   unmapped_read_a: assert property (
      reg_rd_en && !(reg_addr inside {`DGC_ADDR_LGAIN, `DGC_ADDR_RGAIN,
      `DGC_ADDR_COMP}) |=> reg_rdata == `DGC_RD_NONE)
      else $error("unmapped read not zero");
   link_hold_a: assert property ( // R11
      comp_any |-> lch.target == lgain_r && rch.target == rgain_r)
      else $error("gains linked while compressing");
   left_off_a: assert property ( // R6
      !comp_r[`DGC_BIT_LEN] |=> !left_comp_active)
      else $error("left compressor active while disabled");
   right_off_a: assert property ( // R7
      !comp_r[`DGC_BIT_REN] |=> !right_comp_active)
      else $error("right compressor active while disabled");
   gain_now_a: assert property ( // R12
      tick_now_s ##0 legal_left_s ##0 link_sel != `DGC_LINK_R2L
      |=> left_gain_applied == $past(lgain_r))
      else $error("immediate gain not applied");
   unity_pass_a: assert property ( // R13
      sample_tick && step_mode == `DGC_STEP_NOW && lch.target == 8'sh00
      && !lch.comp_en |=> out_valid && left_out == $past(left_in))
      else $error("0 dB sample altered");
   valid_pulse_a: assert property (
      sample_tick |=> out_valid ##1 (out_valid == $past(sample_tick)))
      else $error("output valid not tied to tick");
   right_now_a: assert property ( // R12
      tick_now_s ##0 legal_right_s ##0 link_sel != `DGC_LINK_L2R
      |=> right_gain_applied == $past(rgain_r))
      else $error("immediate right gain not applied");
   right_unity_a: assert property ( // R13
      sample_tick && step_mode == `DGC_STEP_NOW && rch.target == 8'sh00
      && !rch.comp_en |=> right_out == $past(right_in))
      else $error("0 dB right sample altered");
   comp_write_a: assert property ( // R6
      wr_comp |=> comp_r == $past(reg_wdata))
      else $error("compressor control write lost");
   read_hold_a: assert property (
      !reg_rd_en |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   stray_write_a: assert property (
      reg_wr_en && !(reg_addr inside {`DGC_ADDR_LGAIN, `DGC_ADDR_RGAIN,
      `DGC_ADDR_COMP}) |=> $stable(lgain_r) && $stable(rgain_r) &&
      $stable(comp_r))
      else $error("unmapped write changed a register");
   valid_idle_a: assert property (
      !sample_tick |=> !out_valid)
      else $error("output valid without a tick");
   comp_link_a: assert property ( // R11
      tick_now_s ##0 comp_any ##0 legal_left_s ##0 legal_right_s
      |=> left_gain_applied == $past(lgain_r) &&
      right_gain_applied == $past(rgain_r))
      else $error("gains linked while compressing");
   left_on_a: assert property ( // R6
      left_comp_active |-> $past(comp_r[`DGC_BIT_LEN]))
      else $error("left compressor active while bit clear");
   right_on_a: assert property ( // R7
      right_comp_active |-> $past(comp_r[`DGC_BIT_REN]))
      else $error("right compressor active while bit clear");
endmodule

/* File: testbench/tb_dac_gain_and_compressor_cfg.sv */
`include "dgc_params.svh"
module tb_dac_gain_and_compressor_cfg;
   timeunit 1ns;
   timeprecision 1ps;
   logic               core_clk;
   logic               rst;
   logic               reg_wr_en;
   logic               reg_rd_en;
   logic [7:0]         reg_addr;
   logic [7:0]         reg_wdata;
   logic [7:0]         reg_rdata;
   logic [1:0]         step_mode;
   logic [1:0]         link_sel;
   logic               sample_tick;
   dgc_pkg::dgc_smp_t  left_in;
   dgc_pkg::dgc_smp_t  right_in;
   dgc_pkg::dgc_smp_t  left_out;
   dgc_pkg::dgc_smp_t  right_out;
   logic               out_valid;
   dgc_pkg::dgc_gain_t lg;
   dgc_pkg::dgc_gain_t rg;
   logic               lc;
   logic               rc;
   int                 n_errors;
   int                 comparisons;
   localparam logic [7:0]  code_tab [5] = '{8'h00, 8'h0c, 8'hf4, 8'he8, 8'h30};
   localparam logic [15:0] out_tab [5] = '{16'h03e8, 16'h07d0, 16'h01f4,
                                           16'h00fa, 16'h3e80};

   dgc_top uut
   (
      .core_clk           (core_clk),
      .rst                (rst),
      .reg_wr_en          (reg_wr_en),
      .reg_rd_en          (reg_rd_en),
      .reg_addr           (reg_addr),
      .reg_wdata          (reg_wdata),
      .reg_rdata          (reg_rdata),
      .step_mode          (step_mode),
      .link_sel           (link_sel),
      .sample_tick        (sample_tick),
      .left_in            (left_in),
      .right_in           (right_in),
      .left_out           (left_out),
      .right_out          (right_out),
      .out_valid          (out_valid),
      .left_gain_applied  (lg),
      .right_gain_applied (rg),
      .left_comp_active   (lc),
      .right_comp_active  (rc)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset;
      @(posedge core_clk);
      rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr_en <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd_en <= 1'b1;
      reg_addr  <= a;
      @(posedge core_clk);
      reg_rd_en <= 1'b0;
      @(posedge core_clk);
      #1;
      check({8'h00, reg_rdata}, {8'h00, e});
   endtask

   // one sample period; outputs settle once out_valid pulses
   task automatic tick(input logic [15:0] l, input logic [15:0] r);
      int i;
      @(posedge core_clk);
      sample_tick <= 1'b1;
      left_in     <= l;
      right_in    <= r;
      @(posedge core_clk);
      sample_tick <= 1'b0;
      i = 0;
      #1;
      while (out_valid !== 1'b1 && i < 3)
      begin
         @(posedge core_clk);
         #1;
         i++;
      end
      check({15'h0000, out_valid}, 16'h0001);
   endtask

   task automatic t_reset_values;
      rd(`DGC_ADDR_LGAIN, 8'h00);
      rd(`DGC_ADDR_RGAIN, 8'h00);
      rd(`DGC_ADDR_COMP, 8'h0f);
      rd(8'h43, 8'h00);
      check({lg, rg}, 16'h0000);
      check({14'h0000, lc, rc}, 16'h0000);
   endtask

   task automatic t_readback;
      wr(`DGC_ADDR_LGAIN, 8'h30);
      rd(`DGC_ADDR_LGAIN, 8'h30);
      wr(`DGC_ADDR_RGAIN, 8'h81);
      rd(`DGC_ADDR_RGAIN, 8'h81);
      wr(`DGC_ADDR_COMP, 8'h7f);
      rd(`DGC_ADDR_COMP, 8'h7f);
      wr(8'h43, 8'h55);
      rd(8'h43, 8'h00);
      wr(`DGC_ADDR_COMP, 8'h0f);
   endtask

   task automatic t_scale;
      step_mode <= 2'h2;
      for (int k = 0; k < 5; k++)
      begin
         wr(`DGC_ADDR_LGAIN, code_tab[k]);
         wr(`DGC_ADDR_RGAIN, code_tab[k]);
         tick(16'h03e8, 16'hfc18);
         check({8'h00, lg}, {8'h00, code_tab[k]});
         check(left_out, out_tab[k]);
         check(right_out, -out_tab[k]);
      end
      wr(`DGC_ADDR_LGAIN, 8'h81);
      wr(`DGC_ADDR_RGAIN, 8'hff);
      tick(16'h0000, 16'h0000);
      check({lg, rg}, 16'h81ff);
   endtask

   task automatic t_reserved;
      wr(`DGC_ADDR_LGAIN, 8'h50);
      wr(`DGC_ADDR_RGAIN, 8'h80);
      tick(16'h0000, 16'h0000);
      rd(`DGC_ADDR_LGAIN, 8'h50);
      rd(`DGC_ADDR_RGAIN, 8'h80);
      check({lg, rg}, 16'h3081);
   endtask

   task automatic t_ramp(input logic [1:0] mode);
      logic [7:0] e;
      @(posedge core_clk);
      step_mode <= 2'h2;
      wr(`DGC_ADDR_LGAIN, 8'h00);
      wr(`DGC_ADDR_RGAIN, 8'h00);
      tick(16'h0000, 16'h0000);
      @(posedge core_clk);
      step_mode <= mode;
      wr(`DGC_ADDR_LGAIN, 8'h03);
      wr(`DGC_ADDR_RGAIN, 8'h03);
      for (int k = 1; k <= 4; k++)
      begin
         tick(16'h0000, 16'h0000);
         if (mode == 2'h1)
            tick(16'h0000, 16'h0000);
         e = (k > 3) ? 8'h03 : 8'(k);
         check({lg, rg}, {e, e});
      end
   endtask

   task automatic t_link;
      @(posedge core_clk);
      step_mode <= 2'h2;
      wr(`DGC_ADDR_LGAIN, 8'h0c);
      wr(`DGC_ADDR_RGAIN, 8'hf4);
      link_sel <= 2'h1;
      tick(16'h0000, 16'h0000);
      check({lg, rg}, 16'hf4f4);
      @(posedge core_clk);
      link_sel <= 2'h2;
      tick(16'h0000, 16'h0000);
      check({lg, rg}, 16'h0c0c);
      wr(`DGC_ADDR_COMP, 8'h4f);
      tick(16'h0000, 16'h0000);
      check({lg, rg}, 16'h0cf4);
      @(posedge core_clk);
      link_sel <= 2'h0;
      wr(`DGC_ADDR_COMP, 8'h0f);
   endtask

   task automatic t_comp(input logic [7:0] ctl, input logic [15:0] mid,
                         input logic el, input logic er, input logic e2);
      @(posedge core_clk);
      step_mode <= 2'h2;
      wr(`DGC_ADDR_LGAIN, 8'h00);
      wr(`DGC_ADDR_RGAIN, 8'h00);
      wr(`DGC_ADDR_COMP, ctl);
      repeat (4) tick(16'h0bb8, 16'h0bb8);
      check({15'h0000, lc}, {15'h0000, el});
      check({15'h0000, rc}, {15'h0000, er});
      repeat (3) tick(mid, 16'h0000);
      check({14'h0000, lc, rc}, {14'h0000, e2, 1'b0});
      wr(`DGC_ADDR_COMP, 8'h0f);
      tick(16'h0000, 16'h0000);
   endtask

   initial
   begin
      #100000;
      n_errors++;
      report_and_stop();
   end

   initial
   begin
      n_errors    = 0;
      comparisons = 0;
      rst         = 1'b1;
      reg_wr_en   = 1'b0;
      reg_rd_en   = 1'b0;
      reg_addr    = 8'h00;
      reg_wdata   = 8'h00;
      step_mode   = 2'h0;
      link_sel    = 2'h0;
      sample_tick = 1'b0;
      left_in     = 16'h0000;
      right_in    = 16'h0000;
      do_reset();
      t_reset_values();
      t_readback();
      t_scale();
      t_reserved();
      t_ramp(2'h0);
      t_ramp(2'h1);
      t_ramp(2'h3);
      t_link();
      // threshold -24 dB, no hysteresis: 2000 drops out
      t_comp(8'h5c, 16'h07d0, 1'b1, 1'b0, 1'b0);
      // 3 dB hysteresis keeps 2000 engaged
      t_comp(8'h5f, 16'h07d0, 1'b1, 1'b0, 1'b1);
      t_comp(8'h3c, 16'h0000, 1'b0, 1'b1, 1'b0);
      // threshold -3 dB is never reached
      t_comp(8'h60, 16'h0000, 1'b0, 1'b0, 1'b0);
      do_reset();
      t_reset_values();
      report_and_stop();
   end
endmodule
